// >>> fvic_params.svh
// constants of the four-level vectored interrupt controller
// assumes a byte-addressed APB slave with 8 address bits
//
// Overview of operation
// R1 - sample, poll and resolve every machine cycle
// R2 - no call while equal or higher served
// R3 - call only on instruction's last machine cycle
// R4 - no call on config writes or isr exit
// R5 - denied requests are never remembered
// R6 - vectoring clears timer overflow flags
// R7 - ext flags: edge clears, level tracks pin
// R8 - serial and other flags cleared by software
// R9 - call pushes pc, not status word
// R10 - fixed vector address per source
// R11 - isr exit finishes current service level
// R12 - subroutine exit keeps in-service state
// R13 - level is high bit, low bit pair
// R14 - preempt only by strictly higher level
// R15 - higher level wins among simultaneous requests
// R16 - fixed ranking breaks equal level ties
// R17 - enable bits at fixed register positions
// R18 - priority bits mirror enable positions
// R19 - only ext, brownout, watchdog, comparator wake
// R20 - watchdog wakes only on internal rc
// R21 - comparator wakes only with wake enable
// R22 - vector call occupies four machine cycles
// R23 - global enable gates every source
// R24 - one in-service marker per level
// R25 - eligible needs flag, enable and global
`ifndef FVIC_PARAMS_SVH
`define FVIC_PARAMS_SVH

// ============================================================
// register offsets
`define FVIC_OFF_BASE_EN   8'h00
`define FVIC_OFF_EXT_EN    8'h04
`define FVIC_OFF_LVL0_LO   8'h08
`define FVIC_OFF_LVL0_HI   8'h0C
`define FVIC_OFF_LVL1_LO   8'h10
`define FVIC_OFF_LVL1_HI   8'h14
`define FVIC_OFF_FLAGS     8'h18
`define FVIC_OFF_CTRL      8'h1C
`define FVIC_OFF_STATUS    8'h20

// ============================================================
// reset values
`define FVIC_RST_REG8      8'h00
`define FVIC_RST_FLAGS     10'h000

// ============================================================
// field positions
`define FVIC_BIT_GLOBAL    7
`define FVIC_BIT_EXT0      0
`define FVIC_BIT_TMR0      1
`define FVIC_BIT_EXT1      2
`define FVIC_BIT_TMR1      3
`define FVIC_BIT_UART      4
`define FVIC_BIT_CMP       6
`define FVIC_BIT_WDOG      4
`define FVIC_BIT_PWM       5
`define FVIC_BIT_BOUT      6
// flag register layout
`define FVIC_FL_EXT0       0
`define FVIC_FL_TMR0       1
`define FVIC_FL_EXT1       2
`define FVIC_FL_TMR1       3
`define FVIC_FL_UTX        4
`define FVIC_FL_URX        5
`define FVIC_FL_BOUT       6
`define FVIC_FL_WDOG       7
`define FVIC_FL_CMP        8
`define FVIC_FL_PWM        9
// control register layout
`define FVIC_CT_EDGE0      0
`define FVIC_CT_EDGE1      1
`define FVIC_CT_CMPWAKE    5

// ============================================================
// vectors
`define FVIC_VEC_EXT0      16'h0003
`define FVIC_VEC_TMR0      16'h000B
`define FVIC_VEC_EXT1      16'h0013
`define FVIC_VEC_TMR1      16'h001B
`define FVIC_VEC_UART      16'h0023
`define FVIC_VEC_BOUT      16'h002B
`define FVIC_VEC_CMP       16'h0033
`define FVIC_VEC_WDOG      16'h0053
`define FVIC_VEC_PWM       16'h006B

// ============================================================
// timing
`define FVIC_CALL_MCYCLES  3'd4
`define FVIC_NUM_SRC       9

`endif

// >>> fvic_pkg.sv
// types of the four-level vectored interrupt controller
// assumes fvic_params.svh for the numeric constants
package fvic_pkg;

    // ============================================================
    // sequencer states
    typedef enum logic [1:0] {
        FVIC_IDLE = 2'b01,
        FVIC_CALL = 2'b10
    } fvic_state_type;

    // ============================================================
    // core sequencer status, same clock domain
    typedef struct packed {
        logic machStrobe;
        logic lastCycle;
        logic cfgWrite;
        logic isrExit;
        logic subExit;
    } fvic_core_type;

    // one-cycle set pulses from the peripherals, same clock domain
    typedef struct packed {
        logic tmr0;
        logic tmr1;
        logic uartTx;
        logic uartRx;
        logic brownout;
        logic watchdog;
        logic comparator;
        logic pwm;
    } fvic_src_type;

endpackage

// >>> fvic_ctrl.sv
// vectored interrupt controller with four priority levels
// assumes core strobes and peripheral set pulses share mclk,
// the core performs the stack push when it sees the call
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "fvic_params.svh"

module fvic_ctrl import fvic_pkg::*; (
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          arst_n,
    // apb slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    // core sequencer
    input  wire fvic_core_type core,
    output logic               vecCall,
    output logic      [15:0]   vecAddr,
    // sources
    input  wire fvic_src_type  srcSet,
    input  wire logic          ext_irq0_pin,
    input  wire logic          ext_irq1_pin,
    input  wire logic          wdOnRc,
    // status
    output logic               wakeReq,
    output logic      [3:0]    inService
);

    // ============================================================
    // declarations
    logic [31:0]    prdata_q;
    logic           pready_q;
    logic           pslverr_q;
    logic [7:0]     baseEn_q;
    logic [7:0]     extEn_q;
    logic [7:0]     lvl0Lo_q;
    logic [7:0]     lvl0Hi_q;
    logic [7:0]     lvl1Lo_q;
    logic [7:0]     lvl1Hi_q;
    logic [9:0]     flags_q;
    logic [7:0]     ctrl_q;
    logic [3:0]     inSvc_q;
    logic           vecCall_q;
    logic [15:0]    vecAddr_q;
    logic           wake_q;
    logic [3:0]     lastIdx_q;
    logic [2:0]     callCnt_q;
    fvic_state_type state_q;
    logic [2:0]     sync0_q;
    logic [2:0]     sync1_q;
    logic           pin0_q;
    logic           pin1_q;
    logic           prev0_q;
    logic           prev1_q;
    logic           apbWr;
    logic           mapped;
    logic [`FVIC_NUM_SRC-1:0] req;
    logic [1:0]     lvl [`FVIC_NUM_SRC];
    logic           winValid;
    logic [3:0]     winIdx;
    logic [1:0]     winLvl;
    logic           curValid;
    logic [1:0]     curLvl;
    logic           callOk;
    logic           exitNow;
    logic           gEn;

    // ============================================================
    // functions
    function automatic logic [1:0] levelOf(input logic hi, input logic lo);
        return {hi, lo};
    endfunction

    // highest set in-service marker
    function automatic logic [2:0] topOf(input logic [3:0] m);
        logic [2:0] r;
        r = 3'b000;
        for (int i = 0; i < 4; i++) begin
            if (m[i]) begin
                r = {1'b1, 2'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] vecOf(input logic [3:0] idx);
        case (idx)
            4'h0:    vecOf = `FVIC_VEC_EXT0;
            4'h1:    vecOf = `FVIC_VEC_BOUT;
            4'h2:    vecOf = `FVIC_VEC_WDOG;
            4'h3:    vecOf = `FVIC_VEC_TMR0;
            4'h4:    vecOf = `FVIC_VEC_EXT1;
            4'h5:    vecOf = `FVIC_VEC_TMR1;
            4'h6:    vecOf = `FVIC_VEC_UART;
            4'h7:    vecOf = `FVIC_VEC_CMP;
            default: vecOf = `FVIC_VEC_PWM;
        endcase
    endfunction

    // ============================================================
    // apb slave: no wait states, error on unmapped offset
    assign apbWr  = psel && penable && pready_q && pwrite;
    assign mapped = (paddr <= `FVIC_OFF_STATUS) && (paddr[1:0] == 2'b00);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= psel && !penable;
            pslverr_q <= psel && !penable && !mapped;
            prdata_q  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `FVIC_OFF_BASE_EN: prdata_q[7:0] <= baseEn_q;
                    `FVIC_OFF_EXT_EN:  prdata_q[7:0] <= extEn_q;
                    `FVIC_OFF_LVL0_LO: prdata_q[7:0] <= lvl0Lo_q;
                    `FVIC_OFF_LVL0_HI: prdata_q[7:0] <= lvl0Hi_q;
                    `FVIC_OFF_LVL1_LO: prdata_q[7:0] <= lvl1Lo_q;
                    `FVIC_OFF_LVL1_HI: prdata_q[7:0] <= lvl1Hi_q;
                    `FVIC_OFF_FLAGS:   prdata_q[9:0] <= flags_q;
                    `FVIC_OFF_CTRL:    prdata_q[7:0] <= ctrl_q;
                    `FVIC_OFF_STATUS:  prdata_q[7:0] <= {lastIdx_q, inSvc_q};
                    default:           prdata_q      <= 32'h0000_0000;
                endcase
            end
        end
    end

    // configuration registers
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            baseEn_q <= `FVIC_RST_REG8;
            extEn_q  <= `FVIC_RST_REG8;
            lvl0Lo_q <= `FVIC_RST_REG8;
            lvl0Hi_q <= `FVIC_RST_REG8;
            lvl1Lo_q <= `FVIC_RST_REG8;
            lvl1Hi_q <= `FVIC_RST_REG8;
            ctrl_q   <= `FVIC_RST_REG8;
        end else if (apbWr) begin
            case (paddr)
                `FVIC_OFF_BASE_EN: baseEn_q <= pwdata[7:0];
                `FVIC_OFF_EXT_EN:  extEn_q  <= pwdata[7:0];
                `FVIC_OFF_LVL0_LO: lvl0Lo_q <= pwdata[7:0];
                `FVIC_OFF_LVL0_HI: lvl0Hi_q <= pwdata[7:0];
                `FVIC_OFF_LVL1_LO: lvl1Lo_q <= pwdata[7:0];
                `FVIC_OFF_LVL1_HI: lvl1Hi_q <= pwdata[7:0];
                `FVIC_OFF_CTRL:    ctrl_q   <= pwdata[7:0];
                default:           ctrl_q   <= ctrl_q;
            endcase
        end
    end

    // ============================================================
    // external pins: three stages, level moves when last two agree
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sync0_q <= 3'b111;
            sync1_q <= 3'b111;
            pin0_q  <= 1'b1;
            pin1_q  <= 1'b1;
        end else begin
            sync0_q <= {sync0_q[1:0], ext_irq0_pin};
            sync1_q <= {sync1_q[1:0], ext_irq1_pin};
            if (sync0_q[1] == sync0_q[2]) begin
                pin0_q <= sync0_q[2];
            end
            if (sync1_q[1] == sync1_q[2]) begin
                pin1_q <= sync1_q[2];
            end
        end
    end

    // edges count only between machine-cycle samples
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prev0_q <= 1'b1;
            prev1_q <= 1'b1;
        end else if (core.machStrobe) begin
            prev0_q <= pin0_q;
            prev1_q <= pin1_q;
        end
    end

    // ============================================================
    // flags: later assignments win, so hardware set beats any clear
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            flags_q <= `FVIC_RST_FLAGS;
        end else begin
            if (apbWr && paddr == `FVIC_OFF_FLAGS) begin
                flags_q <= pwdata[9:0];                  // see R8
            end
            if (callOk) begin
                case (winIdx)
                    4'h0: if (ctrl_q[`FVIC_CT_EDGE0])
                              flags_q[`FVIC_FL_EXT0] <= 1'b0; // see R7
                    4'h3: flags_q[`FVIC_FL_TMR0] <= 1'b0;     // see R6
                    4'h4: if (ctrl_q[`FVIC_CT_EDGE1])
                              flags_q[`FVIC_FL_EXT1] <= 1'b0; // see R7
                    4'h5: flags_q[`FVIC_FL_TMR1] <= 1'b0;     // see R6
                    default: flags_q <= flags_q;              // see R8
                endcase
            end
            if (srcSet.tmr0)       flags_q[`FVIC_FL_TMR0] <= 1'b1;
            if (srcSet.tmr1)       flags_q[`FVIC_FL_TMR1] <= 1'b1;
            if (srcSet.uartTx)     flags_q[`FVIC_FL_UTX]  <= 1'b1;
            if (srcSet.uartRx)     flags_q[`FVIC_FL_URX]  <= 1'b1;
            if (srcSet.brownout)   flags_q[`FVIC_FL_BOUT] <= 1'b1;
            if (srcSet.watchdog)   flags_q[`FVIC_FL_WDOG] <= 1'b1;
            if (srcSet.comparator) flags_q[`FVIC_FL_CMP]  <= 1'b1;
            if (srcSet.pwm)        flags_q[`FVIC_FL_PWM]  <= 1'b1;
            if (ctrl_q[`FVIC_CT_EDGE0]) begin
                if (core.machStrobe && prev0_q && !pin0_q)
                    flags_q[`FVIC_FL_EXT0] <= 1'b1;
            end else begin
                flags_q[`FVIC_FL_EXT0] <= !pin0_q;        // see R7
            end
            if (ctrl_q[`FVIC_CT_EDGE1]) begin
                if (core.machStrobe && prev1_q && !pin1_q)
                    flags_q[`FVIC_FL_EXT1] <= 1'b1;
            end else begin
                flags_q[`FVIC_FL_EXT1] <= !pin1_q;        // see R7
            end
        end
    end

    // ============================================================
    // eligibility and levels, in ranking order
    assign gEn = baseEn_q[`FVIC_BIT_GLOBAL];            // see R23

    // see R17 R25
    assign req[0] = flags_q[`FVIC_FL_EXT0] && baseEn_q[`FVIC_BIT_EXT0];
    assign req[1] = flags_q[`FVIC_FL_BOUT] && extEn_q[`FVIC_BIT_BOUT];
    assign req[2] = flags_q[`FVIC_FL_WDOG] && extEn_q[`FVIC_BIT_WDOG];
    assign req[3] = flags_q[`FVIC_FL_TMR0] && baseEn_q[`FVIC_BIT_TMR0];
    assign req[4] = flags_q[`FVIC_FL_EXT1] && baseEn_q[`FVIC_BIT_EXT1];
    assign req[5] = flags_q[`FVIC_FL_TMR1] && baseEn_q[`FVIC_BIT_TMR1];
    assign req[6] = (flags_q[`FVIC_FL_UTX] || flags_q[`FVIC_FL_URX])
                    && baseEn_q[`FVIC_BIT_UART];
    assign req[7] = flags_q[`FVIC_FL_CMP]  && baseEn_q[`FVIC_BIT_CMP];
    assign req[8] = flags_q[`FVIC_FL_PWM]  && extEn_q[`FVIC_BIT_PWM];

    // see R13 R18
    assign lvl[0] = levelOf(lvl0Hi_q[`FVIC_BIT_EXT0], lvl0Lo_q[`FVIC_BIT_EXT0]);
    assign lvl[1] = levelOf(lvl1Hi_q[`FVIC_BIT_BOUT], lvl1Lo_q[`FVIC_BIT_BOUT]);
    assign lvl[2] = levelOf(lvl1Hi_q[`FVIC_BIT_WDOG], lvl1Lo_q[`FVIC_BIT_WDOG]);
    assign lvl[3] = levelOf(lvl0Hi_q[`FVIC_BIT_TMR0], lvl0Lo_q[`FVIC_BIT_TMR0]);
    assign lvl[4] = levelOf(lvl0Hi_q[`FVIC_BIT_EXT1], lvl0Lo_q[`FVIC_BIT_EXT1]);
    assign lvl[5] = levelOf(lvl0Hi_q[`FVIC_BIT_TMR1], lvl0Lo_q[`FVIC_BIT_TMR1]);
    assign lvl[6] = levelOf(lvl0Hi_q[`FVIC_BIT_UART], lvl0Lo_q[`FVIC_BIT_UART]);
    assign lvl[7] = levelOf(lvl0Hi_q[`FVIC_BIT_CMP],  lvl0Lo_q[`FVIC_BIT_CMP]);
    assign lvl[8] = levelOf(lvl1Hi_q[`FVIC_BIT_PWM],  lvl1Lo_q[`FVIC_BIT_PWM]);

    // strict compare keeps the earlier rank on a tie
    always_comb begin
        winValid = 1'b0;
        winIdx   = 4'h0;
        winLvl   = 2'b00;
        for (int k = 0; k < `FVIC_NUM_SRC; k++) begin
            if (gEn && req[k] && (!winValid || lvl[k] > winLvl)) begin
                winValid = 1'b1;                         // see R15 R16
                winIdx   = 4'(k);
                winLvl   = lvl[k];
            end
        end
    end

    assign {curValid, curLvl} = topOf(inSvc_q);

    // flags are read live each poll, nothing is held over
    assign callOk = (state_q == FVIC_IDLE) && core.machStrobe  // see R1 R5
                    && core.lastCycle                          // see R3
                    && !core.cfgWrite && !core.isrExit         // see R4
                    && winValid
                    && (!curValid || winLvl > curLvl);         // see R2 R14
    assign exitNow = core.machStrobe && core.lastCycle && core.isrExit;

    // ============================================================
    // call sequencer
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_q   <= FVIC_IDLE;
            callCnt_q <= 3'd0;
            vecCall_q <= 1'b0;
            vecAddr_q <= 16'h0000;
            lastIdx_q <= 4'h0;
        end else begin
            vecCall_q <= callOk;
            case (state_q)
                FVIC_IDLE: begin
                    if (callOk) begin
                        state_q   <= FVIC_CALL;
                        callCnt_q <= 3'd0;
                        // core pushes pc only, status word untouched
                        vecAddr_q <= vecOf(winIdx);     // see R9 R10
                        lastIdx_q <= winIdx;
                    end
                end
                FVIC_CALL: begin
                    if (core.machStrobe) begin
                        callCnt_q <= callCnt_q + 3'd1;
                        if (callCnt_q == `FVIC_CALL_MCYCLES - 3'd1) begin
                            state_q <= FVIC_IDLE;        // see R22
                        end
                    end
                end
                default: state_q <= FVIC_IDLE;
            endcase
        end
    end

    // in-service markers; plain subroutine exit has no effect here
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            inSvc_q <= 4'h0;
        end else if (callOk) begin
            inSvc_q[winLvl] <= 1'b1;                     // see R24
        end else if (exitNow && curValid) begin
            inSvc_q[curLvl] <= 1'b0;                     // see R11 R12
        end
    end

    // ============================================================
    // power-down wake request
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= gEn && (req[0] || req[1] || req[4]      // see R19
                      || (req[2] && wdOnRc)                    // see R20
                      || (req[7] && ctrl_q[`FVIC_CT_CMPWAKE])); // see R21
        end
    end

    assign prdata    = prdata_q;
    assign pready    = pready_q;
    assign pslverr   = pslverr_q;
    assign vecCall   = vecCall_q;
    assign vecAddr   = vecAddr_q;
    assign wakeReq   = wake_q;
    assign inService = inSvc_q;

    // ============================================================
    // assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence s_poll;
        core.machStrobe && core.lastCycle;
    endsequence
    sequence s_call_end;
        (state_q == FVIC_CALL) && core.machStrobe && callCnt_q == 3'd3;
    endsequence

    property p_poll_edge;
        vecCall_q |-> $past(core.machStrobe && core.lastCycle);
    endproperty
    a_poll_edge: assert property (p_poll_edge) // see R1 R3
        else $error("call outside final machine cycle");

    property p_no_cfg;
        s_poll ##0 (core.cfgWrite || core.isrExit) |=> !vecCall_q;
    endproperty
    a_no_cfg: assert property (p_no_cfg) // see R4
        else $error("call during config write or isr exit");

    property p_preempt;
        vecCall_q |-> !$past(curValid) || $past(winLvl) > $past(curLvl);
    endproperty
    a_preempt: assert property (p_preempt) // see R2 R14
        else $error("call without strictly higher level");

    property p_tmr_clear;
        vecCall_q && vecAddr_q == `FVIC_VEC_TMR0 && !$past(srcSet.tmr0)
            |-> !flags_q[`FVIC_FL_TMR0];
    endproperty
    a_tmr_clear: assert property (p_tmr_clear) // see R6
        else $error("timer flag kept after vectoring");

    property p_uart_keep;
        vecCall_q && vecAddr_q == `FVIC_VEC_UART && !$past(apbWr)
            && !$past(srcSet.uartTx || srcSet.uartRx)
            |-> flags_q[5:4] == $past(flags_q[5:4]);
    endproperty
    a_uart_keep: assert property (p_uart_keep) // see R8
        else $error("serial flag cleared by vectoring");

    property p_level_pin;
        !ctrl_q[`FVIC_CT_EDGE0] && $past(!ctrl_q[`FVIC_CT_EDGE0])
            |-> flags_q[`FVIC_FL_EXT0] == !$past(pin0_q);
    endproperty
    a_level_pin: assert property (p_level_pin) // see R7
        else $error("level flag not tracking pin");

    property p_call_len;
        s_call_end |=> state_q == FVIC_IDLE ##0 !vecCall_q;
    endproperty
    a_call_len: assert property (p_call_len) // see R22
        else $error("call length wrong");

    property p_call_busy;
        vecCall_q |-> state_q == FVIC_CALL ##1 !vecCall_q[*3];
    endproperty
    a_call_busy: assert property (p_call_busy) // see R22
        else $error("second call inside call sequence");

    property p_isr_exit;
        exitNow && curValid && !callOk
            |=> inSvc_q == ($past(inSvc_q) & ~(4'h1 << $past(curLvl)));
    endproperty
    a_isr_exit: assert property (p_isr_exit) // see R11
        else $error("isr exit did not retire top level");

    property p_sub_exit;
        core.subExit && !exitNow && !callOk |=> $stable(inSvc_q);
    endproperty
    a_sub_exit: assert property (p_sub_exit) // see R12
        else $error("subroutine exit changed in-service");

    property p_wake;
        !$past(gEn && (req[0] || req[1] || req[4] || req[2] || req[7]))
            |-> !wake_q;
    endproperty
    a_wake: assert property (p_wake) // see R19
        else $error("wake from non-waking source");

    property p_global;
        !$past(gEn) |-> !vecCall_q;
    endproperty
    a_global: assert property (p_global) // see R23
        else $error("call with global enable clear");

endmodule

// >>> fvic_core_model.sv
// core sequencer model: one poll strobe every 4 clocks
// assumes the bench drives the instruction kind levels
`timescale 1ns/100ps
module fvic_core_model import fvic_pkg::*; (
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          arst_n,
    // kind: last cycle, cfg write, isr exit, sub exit
    input  wire logic [3:0]    kind,
    output fvic_core_type      core
);
    logic [1:0] cnt_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n)
            cnt_q <= 2'd0;
        else
            cnt_q <= cnt_q + 2'd1;
    end
    assign core = {cnt_q == 2'd3, kind};
endmodule

// >>> four_level_vectored_interrupt_ctrl_tb_top.sv
// self-checking bench of the vectored interrupt controller
// assumes the core model beside the design, 50 MHz clock
`timescale 1ns/100ps
`include "fvic_params.svh"
module four_level_vectored_interrupt_ctrl_tb_top import fvic_pkg::*;;
    localparam int FB [9] = '{0, 6, 7, 1, 2, 3, 4, 8, 9};
    localparam logic [15:0] VEC [9] = '{`FVIC_VEC_EXT0,
        `FVIC_VEC_BOUT, `FVIC_VEC_WDOG, `FVIC_VEC_TMR0, `FVIC_VEC_EXT1,
        `FVIC_VEC_TMR1, `FVIC_VEC_UART, `FVIC_VEC_CMP, `FVIC_VEC_PWM};
    localparam logic [3:0] BLK [3] = '{4'hc, 4'h0, 4'ha};
    logic          mclk = 0, arst_n = 0, psel = 0, penable = 0;
    logic          pwrite = 0, pready, pslverr, vecCall, wakeReq, err;
    logic [7:0]    paddr = 0;
    logic [31:0]   pwdata = 0, prdata, rd, seed = 32'he7f6;
    logic [15:0]   vecAddr, v;
    logic [3:0]    inService, kind = 4'h8;
    logic          pin1 = 1, wdOnRc = 0;
    fvic_core_type core;
    fvic_src_type  src = '0;
    int            num_errors = 0, compares = 0;

    always #10 mclk = ~mclk;
    fvic_core_model core_u (.mclk(mclk), .arst_n(arst_n), .kind(kind),
        .core(core));
    fvic_ctrl dut_u (.mclk(mclk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .core(core), .vecCall(vecCall),
        .vecAddr(vecAddr), .srcSet(src), .ext_irq0_pin(1'b1),
        .ext_irq1_pin(pin1), .wdOnRc(wdOnRc), .wakeReq(wakeReq),
        .inService(inService));

    // ==========
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    // only timer and edge-mode external flags drop on a call
    function automatic logic [31:0] expFlag(input int f);
        return (f < 4) ? 0 : 1 << f;
    endfunction
    task automatic chk(input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value t=%0t got %h exp %h", $time, seen, exp);
        end
    endtask
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        // idle edge keeps the next setup off this time step
        @(posedge mclk);
    endtask
    // first vector called within n clocks, zero when none
    task automatic waitCall(input int n);
        v = 0;
        repeat (n) begin
            @(negedge mclk);
            if (vecCall === 1'b1 && v == 0)
                v = vecAddr;
            @(posedge mclk);
        end
    endtask
    // one instruction of the given kind spans one strobe
    task automatic insn(input logic [3:0] k);
        kind <= k;
        repeat (4) @(posedge mclk);
        kind <= 4'h8;
        repeat (2) @(posedge mclk);
    endtask
    task automatic test_done;
        $display("compares %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ==========
    // tests
    initial begin
        #400000;
        num_errors++;
        test_done;
    end
    initial begin
        repeat (4) @(posedge mclk);
        arst_n <= 1;
        @(posedge mclk);
        seed = xs(seed);
        apb(1, 8'h18, seed & 10'h3ff);
        apb(0, 8'h18, 0);
        chk(rd, seed & 10'h3fa);
        apb(0, 8'h24, 0);
        chk(err, 1);
        apb(1, 8'h00, 8'h5f);
        apb(1, 8'h04, 8'h70);
        apb(1, 8'h1c, 8'h23);
        waitCall(40);
        chk(v, 0);
        apb(1, 8'h18, 0);
        apb(1, 8'h00, 8'hdf);
        waitCall(40);
        chk(v, 0);
        $display("gating done");
        for (int i = 0; i < 9; i++) begin
            apb(1, 8'h18, 1 << FB[i]);
            waitCall(40);
            chk(v, VEC[i]);
            chk(inService, 1);
            apb(0, 8'h18, 0);
            chk(rd, expFlag(FB[i]));
            apb(1, 8'h18, 0);
            insn(4'h9);
            chk(inService, 1);
            insn(4'ha);
            chk(inService, 0);
        end
        $display("vectors done");
        for (int j = 0; j < 3; j++) begin
            kind <= BLK[j];
            apb(1, 8'h18, 2);
            waitCall(40);
            chk(v, 0);
            apb(1, 8'h18, 0);
        end
        kind <= 4'h8;
        apb(1, 8'h18, 10'h3ff);
        waitCall(40);
        chk(v, VEC[0]);
        apb(1, 8'h18, 0);
        insn(4'ha);
        apb(1, 8'h10, 8'h20);
        apb(1, 8'h14, 8'h20);
        apb(1, 8'h18, 10'h3ff);
        waitCall(40);
        chk(v, `FVIC_VEC_PWM);
        chk(inService, 8);
        apb(1, 8'h18, 10'h102);
        waitCall(40);
        chk(v, 0);
        chk(wakeReq, 1);
        apb(1, 8'h18, 2);
        waitCall(8);
        chk(wakeReq, 0);
        apb(1, 8'h18, 10'h080);
        waitCall(8);
        chk(wakeReq, 0);
        wdOnRc <= 1;
        waitCall(8);
        chk(wakeReq, 1);
        apb(1, 8'h18, 0);
        src.pwm <= 1;
        pin1 <= 0;
        @(posedge mclk);
        src <= '0;
        waitCall(20);
        chk(v, 0);
        apb(0, 8'h18, 0);
        chk(rd, 10'h204);
        chk(wakeReq, 1);
        $display("priority done");
        test_done;
    end
endmodule
